// >>> logic/dup_pkg.sv
// shared constants and types for the dual uart host bus port
package dup_pkg;

  // ==========================================================================
  // bus and register geometry
  localparam int DATA_W   = 8;
  localparam int ADDR_W   = 3;
  localparam int NUM_REGS = 8;

  // register indexes within one channel
  localparam logic [2:0] REG_HOLD   = 3'h0;  // transmit_holding_reg on write
  localparam logic [2:0] REG_IRQ_EN = 3'h1;  // interrupt enable
  localparam logic [2:0] REG_ALT    = 3'h2;  // alternate_function_reg
  localparam logic [2:0] REG_MODEM  = 3'h4;  // modem_control_reg
  localparam logic [2:0] REG_STATUS = 3'h5;  // read-only line status

  // field positions
  localparam int ALT_BCAST_BIT   = 0;  // broadcast writes to both channels
  localparam int MODEM_IR_BIT    = 6;  // infrared line mode
  localparam int IRQ_EN_TX_BIT   = 1;  // holding register empty interrupt
  localparam int STAT_EMPTY_BIT  = 5;  // holding register empty
  localparam int STAT_IDLE_BIT   = 6;  // transmitter fully idle

  // reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] BUS_IDLE  = 8'h00;

  // ==========================================================================
  // serial timing
  localparam int CLOCK_HZ     = 50_000_000;
  localparam int BIT_TIME_NS  = 8680;
  localparam int BIT_CYCLES   = (BIT_TIME_NS * (CLOCK_HZ / 1_000_000)) / 1000;
  localparam int FRAME_BITS   = 10;

  // ==========================================================================
  // one register access travelling to a channel
  typedef struct packed {
    logic             wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } dup_access_t;

  // synchronised pin group
  typedef struct packed {
    logic              chip_sel_n;
    logic              channel_pick;
    logic              read_strobe_n;
    logic              write_strobe_n;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] data;
  } dup_pins_t;

  // pin levels while the host is idle: selects and strobes high
  localparam dup_pins_t PINS_IDLE = '{
    chip_sel_n:     1'b1,
    channel_pick:   1'b1,
    read_strobe_n:  1'b1,
    write_strobe_n: 1'b1,
    reg_addr:       3'h0,
    data:           8'h00
  };

endpackage : dup_pkg

// >>> logic/dup_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module dup_sync #(
  parameter int              W         = 1,
  parameter logic [W-1:0]    RESET_VAL = '0
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         resetn,
  // pins in, filtered out
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  // stage1 feeds only stage2; a bit counts once stages two and three agree
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      stage1 <= RESET_VAL;
      stage2 <= RESET_VAL;
      stage3 <= RESET_VAL;
    end
    else
    begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // per-bit filter: a glitch of one sample never reaches the logic
  always_ff @(posedge clock)
  begin
    if (!resetn)
      level <= RESET_VAL;
    else
      for (int i = 0; i < W; i++)
        if (stage2[i] == stage3[i])
          level[i] <= stage3[i];
  end

endmodule : dup_sync
`default_nettype wire

// >>> logic/dup_serial_tx.sv
// serial shifter with standard and infrared idle levels
`timescale 1ns/1ps
`default_nettype none
module dup_serial_tx #(
  parameter int BIT_CYCLES = dup_pkg::BIT_CYCLES
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  // byte handoff
  input  wire logic       load,
  input  wire logic [7:0] byte_in,
  input  wire logic       ir_mode,
  output logic            busy,
  // line
  output logic            serial_out
);

  // the tick counter is sixteen bits wide, so longer bit times would wrap
  if (BIT_CYCLES < 2 || BIT_CYCLES > 65536)
  begin : g_bad_bit_cycles
    $error("BIT_CYCLES out of range");
  end

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } dup_tx_state_t;

  dup_tx_state_t state;
  logic [9:0]    shift;
  logic [3:0]    bits_left;
  logic [15:0]   tick;
  logic          line_bit;

  // frame is start bit, eight data bits lsb first, stop bit
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      state     <= TX_IDLE;
      shift     <= 10'h3ff;
      bits_left <= 4'h0;
      tick      <= 16'h0000;
    end
    else
    begin
      unique case (state)
        TX_IDLE:
        begin
          if (load)
          begin
            shift     <= {1'b1, byte_in, 1'b0};
            bits_left <= 4'(dup_pkg::FRAME_BITS);
            tick      <= 16'(BIT_CYCLES - 1);
            state     <= TX_SEND;
          end
        end
        TX_SEND:
        begin
          if (tick == 16'h0000)
          begin
            tick      <= 16'(BIT_CYCLES - 1);
            shift     <= {1'b1, shift[9:1]};
            bits_left <= bits_left - 4'h1;
            if (bits_left == 4'h1)
              state <= TX_IDLE;
          end
          else
            tick <= tick - 16'h0001;
        end
      endcase
    end
  end

  assign busy     = (state == TX_SEND);
  assign line_bit = busy ? shift[0] : 1'b1;

  // standard idles high, infrared idles low and pulses for zero bits
  always_ff @(posedge clock)
  begin
    if (!resetn)
      serial_out <= 1'b1;
    else if (ir_mode)
      serial_out <= ~line_bit;
    else
      serial_out <= line_bit;
  end

endmodule : dup_serial_tx
`default_nettype wire

// >>> logic/dup_host_port.sv
// host bus port of a two-channel uart: decode, registers, status pins
// Notes on behaviour
// - read strobe falling starts a read of the addressed register in the chosen channel
// - the read byte drives the data bus; the host samples at strobe rise
// - write strobe rise latches the data bus byte into the addressed register
// - accesses reach a channel only while chip select is low
// - channel pick low targets channel B, high targets channel A
// - alternate function bit 0 makes one write update both channels
// - each channel has an active-high interrupt output requesting service
// - each channel has an active-low transmit ready output from its holding status
// - modem control bit 6 clear: standard mode, transmit idles high and in reset
// - modem control bit 6 set: infrared mode, transmit rests low when idle
// - three address inputs select one of eight registers in the channel
// - eight-bit two-way data bus, driven on reads, received on writes
`timescale 1ns/1ps
`default_nettype none
module dup_host_port #(
  parameter int BIT_CYCLES = dup_pkg::BIT_CYCLES
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  // host strobes and selects
  input  wire logic       chip_sel_n,
  input  wire logic       channel_pick,
  input  wire logic       read_strobe_n,
  input  wire logic       write_strobe_n,
  input  wire logic [2:0] reg_addr,
  // two-way data bus
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe,
  // per-channel status pins
  output logic            irq_chan_a,
  output logic            irq_chan_b,
  output logic            tx_ready_a_n,
  output logic            tx_ready_b_n,
  output logic            serial_out_a,
  output logic            serial_out_b
);

  // ==========================================================================
  // parameter checks
  // the shifter counts bit time in sixteen bits; a longer bit time would wrap
  // and too short a one leaves the tick no room to count down
  if (BIT_CYCLES < 2 || BIT_CYCLES > 65536)
  begin : g_bad_bit_cycles
    $error("BIT_CYCLES out of range");
  end

  // three address bits must reach every register of a channel and no more
  if (dup_pkg::NUM_REGS != (1 << dup_pkg::ADDR_W))
  begin : g_bad_reg_count
    $error("NUM_REGS does not match ADDR_W");
  end

  // ==========================================================================
  // pin synchronisation
  // every host pin, data included, passes the same three-flop filter, so the
  // selects, address and strobes reach the logic in the order the host set
  // them; the price is about four clocks from pin to logic, which is why the
  // host must hold each strobe level and its address for at least that long
  // glitches of one sample are dropped by the agreement of stages two and three
  localparam int PIN_W = $bits(dup_pkg::dup_pins_t);

  dup_pkg::dup_pins_t pins_raw;
  dup_pkg::dup_pins_t pins;
  logic [PIN_W-1:0]   pins_flat;

  // gather the host pins into one carrier word
  assign pins_raw.chip_sel_n     = chip_sel_n;
  assign pins_raw.channel_pick   = channel_pick;
  assign pins_raw.read_strobe_n  = read_strobe_n;
  assign pins_raw.write_strobe_n = write_strobe_n;
  assign pins_raw.reg_addr       = reg_addr;
  assign pins_raw.data           = data_in;

  dup_sync #(
    .W         (PIN_W),
    .RESET_VAL (dup_pkg::PINS_IDLE)
  ) u_sync (
    .clock  (clock),
    .resetn (resetn),
    .pin_in (pins_raw),
    .level  (pins_flat)
  );
  assign pins = dup_pkg::dup_pins_t'(pins_flat);

  // ==========================================================================
  // strobe edges
  // edges come from the filtered levels; the previous-level flops reset to
  // the idle high level, so leaving reset never looks like a fall, and a
  // strobe that moves while deselected starts nothing
  logic rd_prev;
  logic wr_prev;
  logic rd_fall;
  logic wr_fall;
  logic wr_rise;
  logic selected;
  logic wr_armed;

  // previous filtered strobe levels for edge detection
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      rd_prev <= 1'b1;
      wr_prev <= 1'b1;
    end
    else
    begin
      rd_prev <= pins.read_strobe_n;
      wr_prev <= pins.write_strobe_n;
    end
  end

  // a rise needs no select of its own here; the commit checks it again
  assign selected = ~pins.chip_sel_n;
  assign rd_fall  = rd_prev & ~pins.read_strobe_n & selected;
  assign wr_fall  = wr_prev & ~pins.write_strobe_n & selected;
  assign wr_rise  = ~wr_prev & pins.write_strobe_n;

  // a write counts only if its falling edge came while selected,
  // and a deselect in mid-write drops it, so a stray rise commits nothing
  always_ff @(posedge clock)
  begin
    if (!resetn)
      wr_armed <= 1'b0;
    else if (wr_fall)
      wr_armed <= 1'b1;
    else if (wr_rise || pins.chip_sel_n)
      wr_armed <= 1'b0;
  end

  // ==========================================================================
  // channel routing
  // a write lands at the rise of its strobe with the address, data and pick
  // that stand then; a fall seen while deselected arms nothing
  logic                broadcast;
  logic                pick_a;
  logic                commit;
  dup_pkg::dup_access_t acc;
  logic [1:0]          wr_hit;

  // data and address are sampled at the write strobe rise; the filtered data
  // word moves through the same flops as the strobe, so it is settled by then
  assign commit   = wr_rise & wr_armed & selected;
  assign pick_a   = pins.channel_pick;
  assign acc.wr   = commit;
  assign acc.addr = pins.reg_addr;
  assign acc.data = pins.data;
  assign wr_hit[0] = acc.wr & (pick_a | broadcast);
  assign wr_hit[1] = acc.wr & (~pick_a | broadcast);

  // ==========================================================================
  // per-channel register files; index 0 is channel A, 1 is channel B
  // register map of one channel: 0 holding (a write starts a frame, a read
  // returns the last byte), 1 interrupt enable, 2 alternate function,
  // 4 modem control, 5 live status (writes dropped), the rest plain storage;
  // alternate function bit 0 of either channel turns writes into broadcasts
  logic [7:0] regs   [2][dup_pkg::NUM_REGS];
  logic [7:0] status_byte [2];
  logic [1:0] hold_wr;
  logic [1:0] store_wr;
  logic [1:0] hold_full;
  logic [1:0] tx_busy;
  logic [1:0] tx_load;
  logic [1:0] ser_out;
  logic [7:0] rd_byte [2];
  logic [1:0] irq;

  for (genvar c = 0; c < 2; c++)
  begin : g_chan
    // write decode for this channel; the status index takes no writes
    assign store_wr[c] = wr_hit[c] & (acc.addr != dup_pkg::REG_STATUS);
    assign hold_wr[c]  = wr_hit[c] & (acc.addr == dup_pkg::REG_HOLD);

    // plain storage; the status index is read-only
    always_ff @(posedge clock)
    begin
      if (!resetn)
      begin
        for (int r = 0; r < dup_pkg::NUM_REGS; r++)
          regs[c][r] <= dup_pkg::REG_RESET;
      end
      else if (store_wr[c])
        regs[c][acc.addr] <= acc.data;
    end

    // holding register flag: a new write wins over the load that empties it,
    // and the load is held off in a write cycle, so a byte still waiting is overwritten
    always_ff @(posedge clock)
    begin
      if (!resetn)
        hold_full[c] <= 1'b0;
      else if (hold_wr[c])
        hold_full[c] <= 1'b1;
      else if (tx_load[c])
        hold_full[c] <= 1'b0;
    end

    // the load waits out a holding write, so the shifter takes the newest byte
    assign tx_load[c] = hold_full[c] & ~tx_busy[c] & ~hold_wr[c];

    // one shifter per channel; it takes the byte the clock after the write
    // lands, and the line shows the start bit one clock later again
    dup_serial_tx #(
      .BIT_CYCLES (BIT_CYCLES)
    ) u_tx (
      .clock      (clock),
      .resetn     (resetn),
      .load       (tx_load[c]),
      .byte_in    (regs[c][dup_pkg::REG_HOLD]),
      .ir_mode    (regs[c][dup_pkg::REG_MODEM][dup_pkg::MODEM_IR_BIT]),
      .busy       (tx_busy[c]),
      .serial_out (ser_out[c])
    );

    // live status: empty once the shifter has taken the byte, idle once the
    // frame has also left the line
    always_comb
    begin
      status_byte[c]                          = 8'h00;
      status_byte[c][dup_pkg::STAT_EMPTY_BIT] = ~hold_full[c];
      status_byte[c][dup_pkg::STAT_IDLE_BIT]  = ~hold_full[c] & ~tx_busy[c];
    end

    // read view: status is live, everything else reads back as stored
    always_comb
    begin
      if (pins.reg_addr == dup_pkg::REG_STATUS)
        rd_byte[c] = status_byte[c];
      else
        rd_byte[c] = regs[c][pins.reg_addr];
    end

    // service request while enabled and the holding register is empty;
    // it drops only for the cycles in which a byte waits for the shifter
    always_ff @(posedge clock)
    begin
      if (!resetn)
        irq[c] <= 1'b0;
      else
        irq[c] <= regs[c][dup_pkg::REG_IRQ_EN][dup_pkg::IRQ_EN_TX_BIT]
                  & ~hold_full[c];
    end
  end

  // either channel's alternate bit turns writes into broadcasts; reads still
  // follow the channel pick, since one bus cannot carry two bytes, and the
  // write that clears the bit is itself broadcast, so both copies clear
  assign broadcast = regs[0][dup_pkg::REG_ALT][dup_pkg::ALT_BCAST_BIT]
                   | regs[1][dup_pkg::REG_ALT][dup_pkg::ALT_BCAST_BIT];

  // ==========================================================================
  // read data path
  // byte is captured at the strobe fall and held steady until the rise,
  // so the host sees no change while it samples; a read runs: pin fall,
  // filtered fall about four clocks later, byte and drive the clock after,
  // and the drive ends about five clocks after the strobe rise
  logic [7:0] rd_pick_byte;

  // channel choice for reads follows the pick alone
  assign rd_pick_byte = pick_a ? rd_byte[0] : rd_byte[1];

  always_ff @(posedge clock)
  begin
    if (!resetn)
      data_out <= dup_pkg::BUS_IDLE;
    else if (rd_fall)
      data_out <= rd_pick_byte;
  end

  // drive only inside a selected read; release on strobe rise or deselect,
  // so a read that the host abandons by deselecting frees the bus as well
  always_ff @(posedge clock)
  begin
    if (!resetn)
      data_oe <= 1'b0;
    else if (rd_fall)
      data_oe <= 1'b1;
    else if (pins.read_strobe_n || pins.chip_sel_n)
      data_oe <= 1'b0;
  end

  // ==========================================================================
  // status pins
  // transmit ready follows the holding flag, so it reads high only while a
  // byte waits for the shifter; the serial lines come from the shifters' flops
  assign irq_chan_a   = irq[0];
  assign irq_chan_b   = irq[1];
  assign tx_ready_a_n = hold_full[0];
  assign tx_ready_b_n = hold_full[1];
  assign serial_out_a = ser_out[0];
  assign serial_out_b = ser_out[1];

endmodule : dup_host_port
`default_nettype wire

// >>> bench/dup_host_port_sva.sv
// concurrent checks on the host bus port pins
`timescale 1ns/1ps
`default_nettype none
module dup_host_port_sva #(
  parameter int BIT_CYCLES = 4
) (
  // clock and reset
  input wire logic       clock,
  input wire logic       resetn,
  // host side pins
  input wire logic       chip_sel_n,
  input wire logic       channel_pick,
  input wire logic       read_strobe_n,
  input wire logic       write_strobe_n,
  input wire logic [2:0] reg_addr,
  // device side pins
  input wire logic [7:0] data_out,
  input wire logic       data_oe,
  input wire logic       irq_chan_a,
  input wire logic       tx_ready_a_n,
  input wire logic       serial_out_a,
  input wire logic       serial_out_b
);
  // ==========================================================================
  // pin filter costs about four edges, so the windows carry slack
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_rd_sel;
    $fell(read_strobe_n) && !chip_sel_n;
  endsequence
  sequence s_hold_wr;
    $rose(write_strobe_n) && !chip_sel_n && channel_pick && reg_addr == dup_pkg::REG_HOLD;
  endsequence
  AST_RESET_IDLE: assert property ($rose(resetn) |-> serial_out_a && serial_out_b
    && !data_oe && !irq_chan_a && !tx_ready_a_n && data_out == 8'h00)
    else $error("outputs not at reset values");
  AST_RD_DRIVES: assert property (s_rd_sel |-> ##[3:7] data_oe)
    else $error("read did not drive bus");
  AST_RD_RELEASE: assert property ($rose(read_strobe_n) |-> ##[3:7] !data_oe)
    else $error("bus held after read");
  AST_UNSEL_QUIET: assert property (chip_sel_n [*8] |-> !data_oe)
    else $error("bus driven while unselected");
  AST_UNSEL_READ: assert property ($fell(read_strobe_n) && chip_sel_n |-> !data_oe [*8])
    else $error("unselected read drove bus");
  AST_WR_NO_DRIVE: assert property (!write_strobe_n [*6] |-> !data_oe)
    else $error("bus driven during write");
  AST_HOLD_BUSY: assert property (s_hold_wr |-> ##[3:7] tx_ready_a_n)
    else $error("ready pin ignored holding write");
  AST_START_BIT: assert property ($rose(tx_ready_a_n) |-> ##[0:8] !serial_out_a)
    else $error("no start bit after load");
endmodule : dup_host_port_sva
`default_nettype wire

// >>> bench/dup_host_model.sv
// host processor model driving the asynchronous strobes
`timescale 1ns/1ps
`default_nettype none
module dup_host_model (
  // clock
  input  wire logic       clock,
  // pins toward the device
  output logic            chip_sel_n,
  output logic            channel_pick,
  output logic            read_strobe_n,
  output logic            write_strobe_n,
  output logic      [2:0] reg_addr,
  output logic      [7:0] data_in,
  // device bus drive
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe
);
  // ==========================================================================
  logic [7:0] drv;
  logic       driving;
  // released bus shows the inverse so a stale byte never passes
  assign data_in = data_oe ? data_out : (driving ? drv : ~drv);
  initial
  begin
    chip_sel_n = 1'b1;
    channel_pick = 1'b0;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    reg_addr = 3'h0;
    drv = 8'h00;
    driving = 1'b0;
  end
  // one access; strobe held 8 clocks, above the 4 the filter needs
  task automatic access(input logic cs_n, input logic pick, input logic wr,
                        input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clock);
    chip_sel_n <= cs_n;
    channel_pick <= pick;
    reg_addr <= a;
    drv <= d;
    driving <= wr;
    repeat (2) @(posedge clock);
    if (wr)
      write_strobe_n <= 1'b0;
    else
      read_strobe_n <= 1'b0;
    repeat (8) @(posedge clock);
    q = data_in;
    read_strobe_n <= 1'b1;
    write_strobe_n <= 1'b1;
    repeat (8) @(posedge clock);
    chip_sel_n <= 1'b1;
    driving <= 1'b0;
  endtask : access
endmodule : dup_host_model
`default_nettype wire

// >>> bench/dup_host_port_tb_top.sv
// self-checking bench for the host bus port
`timescale 1ns/1ps
`default_nettype none
module dup_host_port_tb_top;
  // ==========================================================================
  localparam int BC = 4;
  logic clock, resetn, chip_sel_n, channel_pick, read_strobe_n, write_strobe_n;
  logic data_oe, irq_chan_a, irq_chan_b, tx_ready_a_n, tx_ready_b_n;
  logic serial_out_a, serial_out_b;
  logic [2:0] reg_addr;
  logic [7:0] data_in, data_out, q, rx;
  int n_mismatch, total_checks, cycles;
  dup_host_port #(.BIT_CYCLES(BC)) dut (.clock(clock), .resetn(resetn),
    .chip_sel_n(chip_sel_n), .channel_pick(channel_pick), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .reg_addr(reg_addr), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .irq_chan_a(irq_chan_a), .irq_chan_b(irq_chan_b),
    .tx_ready_a_n(tx_ready_a_n), .tx_ready_b_n(tx_ready_b_n), .serial_out_a(serial_out_a),
    .serial_out_b(serial_out_b));
  dup_host_model host (.clock(clock), .chip_sel_n(chip_sel_n), .channel_pick(channel_pick),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .reg_addr(reg_addr),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
  // clock and hang guard; the whole run needs well under 3000 cycles
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      n_mismatch++;
      finish_test();
    end
  end
  task finish_test;
    $display("mismatches %0d of %0d checks", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic p, input logic [2:0] a, input logic [7:0] d);
    logic [7:0] x;
    host.access(1'b0, p, 1'b1, a, d, x);
  endtask : wr
  task rd(input logic p, input logic [2:0] a);
    host.access(1'b0, p, 1'b0, a, 8'h00, q);
  endtask : rd
  // sample mid-bit, 1 ns past the edge to stay clear of the update
  task grab;
    int n;
    n = 0;
    while (serial_out_a !== 1'b0 && n < 60)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    repeat (BC / 2 + BC) @(posedge clock);
    #1;
    for (int i = 0; i < 8; i++)
    begin
      rx[i] = serial_out_a;
      repeat (BC) @(posedge clock);
      #1;
    end
  endtask : grab
  // ==========================================================================
  task t_regs;
    for (int p = 0; p < 2; p++)
      for (int a = 6; a < 8; a++)
        wr(p[0], a[2:0], {p[3:0], a[3:0]});
    for (int p = 0; p < 2; p++)
      for (int a = 6; a < 8; a++)
      begin
        rd(p[0], a[2:0]);
        chk(q, {p[3:0], a[3:0]});
      end
  endtask : t_regs
  task t_cs;
    host.access(1'b1, 1'b1, 1'b1, 3'h7, 8'hee, q);
    rd(1'b1, 3'h7);
    chk(q, 8'h17);
    host.access(1'b1, 1'b1, 1'b0, 3'h7, 8'h00, q);
    chk(q, 8'hff);
  endtask : t_cs
  task t_bcast;
    wr(1'b1, dup_pkg::REG_ALT, 8'h01);
    wr(1'b0, 3'h6, 8'hc3);
    rd(1'b1, 3'h6);
    chk(q, 8'hc3);
    wr(1'b0, dup_pkg::REG_ALT, 8'h00);
    wr(1'b0, 3'h6, 8'h11);
    rd(1'b1, 3'h6);
    chk(q, 8'hc3);
  endtask : t_bcast
  task t_tx;
    wr(1'b1, dup_pkg::REG_IRQ_EN, 8'h02);
    fork
      wr(1'b1, dup_pkg::REG_HOLD, 8'h96);
      grab();
    join
    chk(rx, 8'h96);
    repeat (50) @(posedge clock);
    chk({5'h00, irq_chan_a, tx_ready_a_n, serial_out_a}, 8'h05);
    rd(1'b1, dup_pkg::REG_STATUS);
    chk(q, 8'((1 << dup_pkg::STAT_EMPTY_BIT) | (1 << dup_pkg::STAT_IDLE_BIT)));
  endtask : t_tx
  task t_ir;
    wr(1'b0, dup_pkg::REG_IRQ_EN, 8'h02);
    chk({6'h00, irq_chan_b, tx_ready_b_n}, 8'h02);
    wr(1'b0, dup_pkg::REG_MODEM, 8'h40);
    chk({7'h00, serial_out_b}, 8'h00);
    wr(1'b0, dup_pkg::REG_MODEM, 8'h00);
    chk({7'h00, serial_out_b}, 8'h01);
  endtask : t_ir
  // main sequence
  initial
  begin
    resetn = 1'b0;
    n_mismatch = 0;
    total_checks = 0;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    chk({1'b0, irq_chan_a, irq_chan_b, tx_ready_a_n, tx_ready_b_n, serial_out_a,
         serial_out_b, data_oe}, 8'h06);
    t_regs();
    t_cs();
    t_bcast();
    t_tx();
    t_ir();
    finish_test();
  end
endmodule : dup_host_port_tb_top
bind dup_host_port dup_host_port_sva #(.BIT_CYCLES(BIT_CYCLES)) u_sva (.clock(clock),
  .resetn(resetn), .chip_sel_n(chip_sel_n), .channel_pick(channel_pick),
  .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .reg_addr(reg_addr),
  .data_out(data_out), .data_oe(data_oe), .irq_chan_a(irq_chan_a),
  .tx_ready_a_n(tx_ready_a_n), .serial_out_a(serial_out_a), .serial_out_b(serial_out_b));
`default_nettype wire
